// file: srss_pkg.sv
// srss_pkg: constants, register map, state types of the run/stop supervisor
// assumes a single 250 MHz clock and a word-indexed plain register port
package srss_pkg;

   localparam int SRSS_DATA_W = 32;
   localparam int SRSS_ADDR_W = 4;
   localparam int SRSS_PINS = 16;
   localparam int SRSS_CLK_HZ = 250_000_000;
   localparam int SRSS_DISPLAY_HOLD_S = 2;
   localparam int SRSS_DISPLAY_HOLD_CYCLES = SRSS_DISPLAY_HOLD_S * SRSS_CLK_HZ;

   // register word indexes
   localparam logic [3:0] SRSS_REG_CTRL = 4'h0;
   localparam logic [3:0] SRSS_REG_GEAR_NUM = 4'h1;
   localparam logic [3:0] SRSS_REG_GEAR_DEN = 4'h2;
   localparam logic [3:0] SRSS_REG_PPR = 4'h3;
   localparam logic [3:0] SRSS_REG_STATUS = 4'h4;
   localparam logic [3:0] SRSS_REG_CMD_COUNT = 4'h5;
   localparam logic [3:0] SRSS_REG_FB_COUNT = 4'h6;
   localparam logic [3:0] SRSS_REG_DROOP = 4'h7;
   localparam logic [3:0] SRSS_REG_IRQ_STATUS = 4'h8;
   localparam logic [3:0] SRSS_REG_IRQ_ENABLE = 4'h9;
   localparam logic [3:0] SRSS_REG_IRQ_CLEAR = 4'hA;

   // control register fields
   localparam int SRSS_CTRL_MODE_LSB = 0;
   localparam int SRSS_CTRL_GEAR_SEL = 2;
   localparam int SRSS_CTRL_FORM_LSB = 3;
   localparam int SRSS_CTRL_ENC_WIRE = 5;

   // pin positions in the input vector
   localparam int SRSS_PIN_SON = 0;
   localparam int SRSS_PIN_ST1 = 1;
   localparam int SRSS_PIN_ST2 = 2;
   localparam int SRSS_PIN_LSP = 3;
   localparam int SRSS_PIN_LSN = 4;
   localparam int SRSS_PIN_EM1 = 5;
   localparam int SRSS_PIN_EM2 = 6;
   localparam int SRSS_PIN_CR = 7;
   localparam int SRSS_PIN_RES = 8;
   localparam int SRSS_PIN_PA = 9;
   localparam int SRSS_PIN_PB = 10;
   localparam int SRSS_PIN_EA = 11;
   localparam int SRSS_PIN_EB = 12;
   localparam int SRSS_PIN_ALM = 13;
   localparam int SRSS_PIN_ALM_DB = 14;
   localparam int SRSS_PIN_ENC4 = 15;

   localparam logic [1:0] SRSS_MODE_POSITION = 2'h0;
   localparam logic [1:0] SRSS_MODE_SPEED = 2'h1;
   localparam logic [1:0] SRSS_MODE_TORQUE = 2'h2;

   localparam logic [1:0] SRSS_FORM_PULSE_SIGN = 2'h0;
   localparam logic [1:0] SRSS_FORM_FWD_REV = 2'h1;
   localparam logic [1:0] SRSS_FORM_QUAD = 2'h2;

   localparam logic [31:0] SRSS_GEAR_FULL = 32'h0002_0000;
   localparam logic [7:0] SRSS_CODE_FORCED_STOP = 8'hE6;
   localparam logic [7:0] SRSS_CODE_ENC_INIT = 8'h16;

   localparam int SRSS_IRQ_ALARM = 0;
   localparam int SRSS_IRQ_FORCED_STOP = 1;
   localparam int SRSS_IRQ_ENC_ERR = 2;
   localparam int SRSS_IRQ_STROKE = 3;
   localparam int SRSS_IRQ_W = 4;

   localparam logic [1:0] SRSS_RST_MODE = 2'h1;
   localparam logic [31:0] SRSS_RST_GEAR = 32'h0000_0001;
   localparam logic [31:0] SRSS_RST_PPR = 32'h0000_0FA0;

   typedef enum logic [2:0] {
      STOP_RUN,
      STOP_COAST,
      STOP_DECEL,
      STOP_DYN_BRAKE,
      STOP_LOCK
   } srss_stop_type;

   typedef struct packed {
      logic base_drive_on;
      logic decel_stop;
      logic dyn_brake_on;
      logic servo_lock;
      logic fwd_allow;
      logic rev_allow;
   } srss_drive_type;

   typedef struct packed {
      logic [SRSS_PINS-1:0] sync1;
      logic [SRSS_PINS-1:0] sync2;
      logic [SRSS_PINS-1:0] prev;
      logic [1:0] mode;
      logic gear_sel;
      logic [1:0] form;
      logic enc_wire;
      logic [31:0] num;
      logic [31:0] den;
      logic [31:0] ppr;
      logic [31:0] cmd_count;
      logic [31:0] fb_count;
      logic [31:0] target;
      logic signed [39:0] acc;
      logic alarm_latched;
      logic alarm_db;
      logic enc_err;
      logic em2_warn;
      srss_stop_type stop;
      srss_drive_type drive;
      logic [7:0] warn_code;
      logic [SRSS_IRQ_W-1:0] irq_status;
      logic [SRSS_IRQ_W-1:0] irq_enable;
      logic irq;
      logic [31:0] disp_count;
      logic disp_data;
      logic [31:0] rdata;
   } srss_state_type;

endpackage : srss_pkg

// file: srss_supervisor.sv
// srss_supervisor: run/stop supervision, pulse counting and electronic gear
// assumes discrete pins arrive asynchronously and software uses the plain register port
//
// Behaviour
// - servo-on going off removes base drive at once so the motor coasts.
// - an alarm brings a commanded deceleration, or the dynamic brake for braking alarms.
// - forced stop two going off decelerates the motor and raises the forced-stop warning.
// - in torque mode forced stop two acts exactly as forced stop one.
// - a stroke-end input going off stops and servo-locks the motor, opposite motion allowed.
// - in speed mode, both start inputs on or both off decelerate the motor to a stop.
// - after power-up the display shows the speed symbol and switches to data 2 s later.
// - the controller's output pulse count equals the device's cumulative command count.
// - with gear select 0 feedback equals command times numerator over denominator.
// - with gear select 1 feedback equals command times 131072 over pulses per revolution.
// - servo-off, stroke-end off, clear or reset discard pending command motion.
// - the control mode comes from the mode-select setting.
// - a four-wire encoder needs the wiring setting at 1, else the encoder error is raised.
// - the command pulse train is decoded per the selectable input form.
`timescale 1ns/100ps
`default_nettype none

module srss_supervisor
   import srss_pkg::*;
#(
   parameter int DISPLAY_HOLD_CYCLES = SRSS_DISPLAY_HOLD_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [SRSS_PINS-1:0] pins,
   input wire logic [SRSS_ADDR_W-1:0] reg_addr,
   input wire logic [SRSS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [SRSS_DATA_W-1:0] reg_rdata,
   output srss_drive_type drive,
   output logic [7:0] warn_code,
   output logic display_data,
   output logic irq
);

   srss_state_type s;
   srss_state_type n;

   logic [SRSS_PINS-1:0] cur;
   logic [SRSS_PINS-1:0] old;
   logic [1:0] cmd_step;
   logic [1:0] fb_step;
   logic [31:0] mult;
   logic [31:0] divisor;
   logic signed [39:0] den_s;
   logic [SRSS_IRQ_W-1:0] events;
   logic servo_on_input;
   logic forward_stroke_end;
   logic reverse_stroke_end;
   logic em1_stop;
   logic em2_stop;
   logic start_bad;
   logic discard;
   logic cmd_ok;

   // returns {step, up}; one step per edge in x4 quadrature
   function automatic logic [1:0] srss_quad(
      input logic a_o,
      input logic b_o,
      input logic a_n,
      input logic b_n
   );
      logic moved;
      moved = (a_o ^ a_n) ^ (b_o ^ b_n);
      return {moved, a_n ^ b_o};
   endfunction : srss_quad

   always_comb
   begin
      n = s;
      n.sync1 = pins;
      n.sync2 = s.sync1;
      n.prev = s.sync2;
      cur = s.sync2;
      old = s.prev;
      servo_on_input = cur[SRSS_PIN_SON];
      forward_stroke_end = cur[SRSS_PIN_LSP];
      reverse_stroke_end = cur[SRSS_PIN_LSN];
      events = '0;

      // command pulse decode
      case (s.form)
         SRSS_FORM_PULSE_SIGN:
         begin
            cmd_step = {cur[SRSS_PIN_PA] & ~old[SRSS_PIN_PA], cur[SRSS_PIN_PB]};
         end
         SRSS_FORM_FWD_REV:
         begin
            cmd_step[1] = (cur[SRSS_PIN_PA] & ~old[SRSS_PIN_PA])
               ^ (cur[SRSS_PIN_PB] & ~old[SRSS_PIN_PB]);
            cmd_step[0] = cur[SRSS_PIN_PA] & ~old[SRSS_PIN_PA];
         end
         SRSS_FORM_QUAD:
         begin
            cmd_step = srss_quad(old[SRSS_PIN_PA], old[SRSS_PIN_PB],
               cur[SRSS_PIN_PA], cur[SRSS_PIN_PB]);
         end
         default:
         begin
            cmd_step = 2'h0;
         end
      endcase
      fb_step = srss_quad(old[SRSS_PIN_EA], old[SRSS_PIN_EB],
         cur[SRSS_PIN_EA], cur[SRSS_PIN_EB]);

      // cumulative counters, what the controller output count is checked against
      if (cmd_step[1])
      begin
         n.cmd_count = cmd_step[0] ? s.cmd_count + 32'h0000_0001 : s.cmd_count - 32'h0000_0001;
      end
      if (fb_step[1])
      begin
         n.fb_count = fb_step[0] ? s.fb_count + 32'h0000_0001 : s.fb_count - 32'h0000_0001;
      end

      // encoder wiring check and alarm latches
      if (cur[SRSS_PIN_ENC4] != s.enc_wire)
      begin
         n.enc_err = 1'b1;
      end
      else if (cur[SRSS_PIN_RES])
      begin
         n.enc_err = 1'b0;
      end
      if (cur[SRSS_PIN_ALM] | n.enc_err)
      begin
         n.alarm_latched = 1'b1;
         n.alarm_db = s.alarm_db | cur[SRSS_PIN_ALM_DB];
      end
      else if (cur[SRSS_PIN_RES])
      begin
         n.alarm_latched = 1'b0;
         n.alarm_db = 1'b0;
      end

      // forced stops; in torque mode stop two takes the stop one path
      em1_stop = ~cur[SRSS_PIN_EM1]
         | (~cur[SRSS_PIN_EM2] & (s.mode == SRSS_MODE_TORQUE));
      em2_stop = ~cur[SRSS_PIN_EM2] & (s.mode != SRSS_MODE_TORQUE);
      n.em2_warn = em2_stop;
      // start pair only steers stopping in speed control
      start_bad = (s.mode == SRSS_MODE_SPEED)
         & (cur[SRSS_PIN_ST1] == cur[SRSS_PIN_ST2]);

      // stop selection, most severe first
      if (!servo_on_input)
      begin
         n.stop = STOP_COAST;
      end
      else if (em1_stop | (n.alarm_latched & n.alarm_db))
      begin
         n.stop = STOP_DYN_BRAKE;
      end
      else if (n.alarm_latched | em2_stop)
      begin
         n.stop = STOP_DECEL;
      end
      else if (!forward_stroke_end | !reverse_stroke_end)
      begin
         n.stop = STOP_LOCK;
      end
      else if (start_bad)
      begin
         n.stop = STOP_DECEL;
      end
      else
      begin
         n.stop = STOP_RUN;
      end

      n.drive = '0;
      case (n.stop)
         STOP_RUN:
         begin
            n.drive.base_drive_on = 1'b1;
            n.drive.fwd_allow = 1'b1;
            n.drive.rev_allow = 1'b1;
         end
         STOP_COAST:
         begin
            n.drive.base_drive_on = 1'b0;
         end
         STOP_DECEL:
         begin
            n.drive.base_drive_on = 1'b1;
            n.drive.decel_stop = 1'b1;
         end
         STOP_DYN_BRAKE:
         begin
            n.drive.dyn_brake_on = 1'b1;
         end
         STOP_LOCK:
         begin
            n.drive.base_drive_on = 1'b1;
            n.drive.servo_lock = 1'b1;
            n.drive.fwd_allow = forward_stroke_end;
            n.drive.rev_allow = reverse_stroke_end;
         end
         default:
         begin
            n.drive = '0;
         end
      endcase

      if (s.em2_warn)
      begin
         n.warn_code = SRSS_CODE_FORCED_STOP;
      end
      else if (s.enc_err)
      begin
         n.warn_code = SRSS_CODE_ENC_INIT;
      end
      else
      begin
         n.warn_code = 8'h00;
      end

      // electronic gear; one output step per cycle, so the command rate must stay
      // below clock rate divided by the gear ratio
      mult = s.gear_sel ? SRSS_GEAR_FULL : s.num;
      divisor = s.gear_sel ? s.ppr : s.den;
      den_s = $signed({8'h00, divisor});
      cmd_ok = cmd_step[1] & (cmd_step[0] ? s.drive.fwd_allow : s.drive.rev_allow);
      discard = !servo_on_input | (old[SRSS_PIN_LSP] & !forward_stroke_end) | (old[SRSS_PIN_LSN] & !reverse_stroke_end)
         | cur[SRSS_PIN_CR] | cur[SRSS_PIN_RES];
      if (discard)
      begin
         n.target = n.fb_count;
         n.acc = '0;
      end
      else
      begin
         if (cmd_ok)
         begin
            n.acc = cmd_step[0] ? s.acc + $signed({8'h00, mult})
               : s.acc - $signed({8'h00, mult});
         end
         if (divisor == 32'h0000_0000)
         begin
            n.acc = '0;
         end
         else if (n.acc >= den_s)
         begin
            n.acc = n.acc - den_s;
            n.target = s.target + 32'h0000_0001;
         end
         else if (n.acc <= -den_s)
         begin
            n.acc = n.acc + den_s;
            n.target = s.target - 32'h0000_0001;
         end
      end

      // power-up display: speed symbol, then data after the hold time
      if (!s.disp_data)
      begin
         if (s.disp_count == DISPLAY_HOLD_CYCLES - 1)
         begin
            n.disp_data = 1'b1;
         end
         else
         begin
            n.disp_count = s.disp_count + 32'h0000_0001;
         end
      end

      events[SRSS_IRQ_ALARM] = n.alarm_latched & ~s.alarm_latched;
      events[SRSS_IRQ_FORCED_STOP] = n.em2_warn & ~s.em2_warn;
      events[SRSS_IRQ_ENC_ERR] = n.enc_err & ~s.enc_err;
      events[SRSS_IRQ_STROKE] = (old[SRSS_PIN_LSP] & !forward_stroke_end) | (old[SRSS_PIN_LSN] & !reverse_stroke_end);

      // register writes
      if (reg_wr)
      begin
         if (reg_addr == SRSS_REG_CTRL)
         begin
            n.mode = reg_wdata[SRSS_CTRL_MODE_LSB +: 2];
            n.gear_sel = reg_wdata[SRSS_CTRL_GEAR_SEL];
            n.form = reg_wdata[SRSS_CTRL_FORM_LSB +: 2];
            n.enc_wire = reg_wdata[SRSS_CTRL_ENC_WIRE];
         end
         else if (reg_addr == SRSS_REG_GEAR_NUM)
         begin
            n.num = reg_wdata;
         end
         else if (reg_addr == SRSS_REG_GEAR_DEN)
         begin
            n.den = reg_wdata;
         end
         else if (reg_addr == SRSS_REG_PPR)
         begin
            n.ppr = reg_wdata;
         end
         else if (reg_addr == SRSS_REG_IRQ_ENABLE)
         begin
            n.irq_enable = reg_wdata[SRSS_IRQ_W-1:0];
         end
      end
      // a new event wins over a clear in the same cycle
      n.irq_status = s.irq_status | events;
      if (reg_wr && reg_addr == SRSS_REG_IRQ_CLEAR)
      begin
         n.irq_status = (s.irq_status & ~reg_wdata[SRSS_IRQ_W-1:0]) | events;
      end
      n.irq = |(n.irq_status & n.irq_enable);

      // register reads, data valid the cycle after the strobe only
      n.rdata = '0;
      if (reg_rd)
      begin
         if (reg_addr == SRSS_REG_CTRL)
         begin
            n.rdata[SRSS_CTRL_MODE_LSB +: 2] = s.mode;
            n.rdata[SRSS_CTRL_GEAR_SEL] = s.gear_sel;
            n.rdata[SRSS_CTRL_FORM_LSB +: 2] = s.form;
            n.rdata[SRSS_CTRL_ENC_WIRE] = s.enc_wire;
         end
         else if (reg_addr == SRSS_REG_GEAR_NUM)
         begin
            n.rdata = s.num;
         end
         else if (reg_addr == SRSS_REG_GEAR_DEN)
         begin
            n.rdata = s.den;
         end
         else if (reg_addr == SRSS_REG_PPR)
         begin
            n.rdata = s.ppr;
         end
         else if (reg_addr == SRSS_REG_STATUS)
         begin
            n.rdata = {s.warn_code, s.sync2, s.disp_data, s.alarm_latched, s.enc_err,
               s.stop, s.drive[5:4]};
         end
         else if (reg_addr == SRSS_REG_CMD_COUNT)
         begin
            n.rdata = s.cmd_count;
         end
         else if (reg_addr == SRSS_REG_FB_COUNT)
         begin
            n.rdata = s.fb_count;
         end
         else if (reg_addr == SRSS_REG_DROOP)
         begin
            n.rdata = s.target - s.fb_count;
         end
         else if (reg_addr == SRSS_REG_IRQ_STATUS)
         begin
            n.rdata[SRSS_IRQ_W-1:0] = s.irq_status;
         end
         else if (reg_addr == SRSS_REG_IRQ_ENABLE)
         begin
            n.rdata[SRSS_IRQ_W-1:0] = s.irq_enable;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         // synchronisers keep running through reset so release shows no false pin edge
         s.sync1 <= n.sync1;
         s.sync2 <= n.sync2;
         s.prev <= n.prev;
         s.stop <= STOP_COAST;
         s.mode <= SRSS_RST_MODE;
         s.num <= SRSS_RST_GEAR;
         s.den <= SRSS_RST_GEAR;
         s.ppr <= SRSS_RST_PPR;
      end
      else
      begin
         s <= n;
      end
   end

   assign reg_rdata = s.rdata;
   assign drive = s.drive;
   assign warn_code = s.warn_code;
   assign display_data = s.disp_data;
   assign irq = s.irq;

endmodule : srss_supervisor

`default_nettype wire

// file: srss_ctrl_model.sv
// srss_ctrl_model: motion controller model driving the command pulse pair
// assumes the bench calls send() from one process at a time
`timescale 1ns/100ps
`default_nettype none
module srss_ctrl_model
   import srss_pkg::*;
(
   input wire logic clk,
   output logic pa,
   output logic pb,
   output logic [31:0] q_count
);
   logic [1:0] ph;
   initial
   begin
      pa = 1'b0;
      pb = 1'b0;
      ph = 2'h0;
      q_count = 32'h0;
   end
   // at least four cycles per level: slower pulses would only lengthen the run, faster ones
   // could outrun the gear, which gives one output step per cycle
   task automatic send(input int n, input logic [1:0] form);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         if (form == SRSS_FORM_QUAD)
         begin
            ph = ph + 2'h1;
            pa <= ph[0] ^ ph[1];
            pb <= ph[1];
         end
         else
         begin
            pb <= (form == SRSS_FORM_PULSE_SIGN);
            repeat (4) @(posedge clk);
            pa <= 1'b1;
            repeat (4) @(posedge clk);
            pa <= 1'b0;
         end
         q_count <= q_count + 32'h1;
         repeat (4) @(posedge clk);
      end
   endtask : send
endmodule : srss_ctrl_model
`default_nettype wire

// file: srss_supervisor_assertions.sv
// srss_supervisor_assertions: port checker of the run/stop supervisor
// assumes it is bound onto srss_supervisor; one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module srss_supervisor_checker
   import srss_pkg::*;
#(
   parameter int DISPLAY_HOLD_CYCLES = 20
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [SRSS_PINS-1:0] pins,
   input wire logic [SRSS_ADDR_W-1:0] reg_addr,
   input wire logic [SRSS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [SRSS_DATA_W-1:0] reg_rdata,
   input wire srss_drive_type drive,
   input wire logic [7:0] warn_code,
   input wire logic display_data,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic [1:0] mode_q;
   int cnt;
   wire logic servo_on_input = pins[SRSS_PIN_SON];
   wire logic em1 = pins[SRSS_PIN_EM1];
   wire logic em2 = pins[SRSS_PIN_EM2];
   // a latched alarm is invisible here, so only pin causes are excluded
   wire logic ok = servo_on_input & em1 & em2 & ~pins[SRSS_PIN_ALM] & ~pins[SRSS_PIN_ENC4];
   wire logic lim = pins[SRSS_PIN_LSP] & pins[SRSS_PIN_LSN];
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_q <= SRSS_RST_MODE;
         cnt <= 0;
      end
      else
      begin
         if (reg_wr && reg_addr == SRSS_REG_CTRL)
         begin
            mode_q <= reg_wdata[1:0];
         end
         if (cnt < DISPLAY_HOLD_CYCLES + 3)
         begin
            cnt <= cnt + 1;
         end
      end
   end
   a_coast_son: assert property ((!servo_on_input)[*3] |=> !drive.base_drive_on)
      else $error("base drive stayed on");
   a_brake_em1: assert property ((servo_on_input && !em1)[*3] |=> drive.dyn_brake_on)
      else $error("no dynamic brake");
   a_decel_warn: assert property (
      (mode_q != SRSS_MODE_TORQUE && servo_on_input && em1 && !em2)[*5]
      |=> warn_code == SRSS_CODE_FORCED_STOP) else $error("no forced stop warning");
   a_stroke_lock: assert property ((ok && !pins[SRSS_PIN_LSP] && pins[SRSS_PIN_LSN])[*3]
      |=> drive.servo_lock && !drive.fwd_allow && drive.rev_allow) else $error("no lock");
   a_starts_decel: assert property ((mode_q == SRSS_MODE_SPEED && ok && lim
      && pins[SRSS_PIN_ST1] == pins[SRSS_PIN_ST2])[*3] |=> drive.decel_stop)
      else $error("equal starts did not decelerate");
   a_display_wait: assert property (cnt < DISPLAY_HOLD_CYCLES - 1 |-> !display_data)
      else $error("data shown early");
   a_display_show: assert property (cnt == DISPLAY_HOLD_CYCLES + 3 |-> display_data)
      else $error("data not shown");
   a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its cycle");
   a_reset_quiet: assert property ($fell(rst) |-> drive == '0 && !display_data
      && warn_code == 8'h00 && !irq) else $error("outputs not at reset values");
   c_lock: cover property (drive.servo_lock);
   c_brake: cover property (drive.dyn_brake_on);
   c_irq: cover property ($rose(irq));
endmodule : srss_supervisor_checker
bind srss_supervisor srss_supervisor_checker #(.DISPLAY_HOLD_CYCLES(DISPLAY_HOLD_CYCLES)) chk (
   .clk(clk), .rst(rst), .pins(pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive(drive),
   .warn_code(warn_code), .display_data(display_data), .irq(irq));
`default_nettype wire

// file: srss_supervisor_tb_top.sv
// srss_supervisor_tb_top: self-checking bench of the run/stop supervisor
// assumes srss_pkg, the design and the controller model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module srss_supervisor_tb_top
   import srss_pkg::*;
   ;
   typedef struct packed {logic [31:0] e; logic [31:0] m;} srss_note_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] p;
   wire logic [15:0] pins;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, q_count;
   wire logic [31:0] reg_rdata;
   logic reg_wr, reg_rd, display_data, irq, pa, pb, g;
   logic rd_q = 1'b0;
   logic [1:0] f;
   logic [7:0] warn_code;
   srss_drive_type drive;
   srss_note_type notes[$];
   srss_note_type nt;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n, ex;
   assign pins = {p[15:11], pb, pa, p[8:0]};
   initial forever #2 clk = ~clk;
   srss_supervisor #(.DISPLAY_HOLD_CYCLES(20)) dut (.clk(clk), .rst(rst), .pins(pins),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .drive(drive), .warn_code(warn_code),
      .display_data(display_data), .irq(irq));
   srss_ctrl_model ctrl (.clk(clk), .pa(pa), .pb(pb), .q_count(q_count));
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{e, m});
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   // six cycles cover the two sync flops and the registered decision
   task automatic pin(input int i, input logic v);
      @(posedge clk);
      p[i] <= v;
      repeat (6) @(posedge clk);
   endtask : pin
   task automatic results;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   always @(posedge clk)
   begin
      rd_q <= reg_rd;
      if (rd_q)
      begin
         nt = notes.pop_front();
         `CHK(reg_rdata & nt.m, nt.e)
      end
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         results();
      end
   end
   initial
   begin
      void'($urandom(67975));
      p = 16'h0078; // stroke ends and forced stops on, servo-on and both starts off before power
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(SRSS_REG_CTRL, 32'h1, 32'h3F);
      rd(SRSS_REG_GEAR_NUM, 32'h1, '1);
      rd(SRSS_REG_GEAR_DEN, 32'h1, '1);
      rd(SRSS_REG_PPR, 32'hFA0, '1);
      rd(4'hF, 32'h0, '1);
      rd(SRSS_REG_STATUS, 32'h04, 32'h9F);
      repeat (25) @(posedge clk);
      rd(SRSS_REG_STATUS, 32'h80, 32'h80);
      `CHK(display_data, 1'b1)
      pin(SRSS_PIN_SON, 1'b1);
      rd(SRSS_REG_STATUS, 32'h08, 32'h1C);
      pin(SRSS_PIN_ST1, 1'b1);
      rd(SRSS_REG_STATUS, 32'h00, 32'h1C);
      pin(SRSS_PIN_ST2, 1'b1);
      rd(SRSS_REG_STATUS, 32'h08, 32'h1C);
      pin(SRSS_PIN_ST2, 1'b0);
      wr(SRSS_REG_GEAR_NUM, 32'h3);
      wr(SRSS_REG_GEAR_DEN, 32'h2);
      wr(SRSS_REG_PPR, 32'h0001_0000);
      // cases of gear select and input form: (0,0) (1,0) (0,1) (0,2)
      for (int k = 0; k < 4; k++)
      begin
         g = (k == 1);
         f = (k < 2) ? 2'h0 : 2'(k - 1);
         wr(SRSS_REG_CTRL, {26'h0, 1'b0, f, g, SRSS_MODE_SPEED});
         pin(SRSS_PIN_CR, 1'b1);
         pin(SRSS_PIN_CR, 1'b0);
         rd(SRSS_REG_DROOP, 32'h0, '1);
         n = 1 + $urandom % 6;
         ctrl.send(n, f);
         repeat (8) @(posedge clk);
         ex = g ? 2 * n : (3 * n) / 2;
         rd(SRSS_REG_DROOP, ex, '1);
      end
      rd(SRSS_REG_CMD_COUNT, q_count, '1);
      rd(SRSS_REG_FB_COUNT, 32'h0, '1);
      wr(SRSS_REG_IRQ_ENABLE, 32'h0);
      pin(SRSS_PIN_LSP, 1'b0);
      rd(SRSS_REG_STATUS, 32'h10, 32'h1C);
      `CHK({drive.fwd_allow, drive.rev_allow}, 2'b01)
      rd(SRSS_REG_IRQ_STATUS, 32'h8, 32'h8);
      `CHK(irq, 1'b0)
      wr(SRSS_REG_IRQ_ENABLE, 32'hF);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      wr(SRSS_REG_IRQ_CLEAR, 32'h8);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      rd(SRSS_REG_IRQ_STATUS, 32'h0, 32'h8);
      pin(SRSS_PIN_LSP, 1'b1);
      pin(SRSS_PIN_EM2, 1'b0);
      rd(SRSS_REG_STATUS, 32'hE600_0008, 32'hFF00_001C);
      `CHK(warn_code, SRSS_CODE_FORCED_STOP)
      pin(SRSS_PIN_EM2, 1'b1);
      wr(SRSS_REG_CTRL, {30'h0, SRSS_MODE_TORQUE});
      pin(SRSS_PIN_EM2, 1'b0);
      rd(SRSS_REG_STATUS, 32'h0C, 32'h1C);
      pin(SRSS_PIN_EM2, 1'b1);
      wr(SRSS_REG_CTRL, 32'h1);
      pin(SRSS_PIN_EM1, 1'b0);
      rd(SRSS_REG_STATUS, 32'h0C, 32'h1C);
      pin(SRSS_PIN_EM1, 1'b1);
      for (int d = 0; d < 2; d++)
      begin
         pin(SRSS_PIN_ALM_DB, d[0]);
         pin(SRSS_PIN_ALM, 1'b1);
         rd(SRSS_REG_STATUS, d ? 32'h0C : 32'h08, 32'h1C);
         pin(SRSS_PIN_ALM, 1'b0);
         pin(SRSS_PIN_RES, 1'b1);
         pin(SRSS_PIN_RES, 1'b0);
         rd(SRSS_REG_STATUS, 32'h00, 32'h1C);
      end
      pin(SRSS_PIN_ALM_DB, 1'b0);
      pin(SRSS_PIN_ENC4, 1'b1);
      rd(SRSS_REG_STATUS, 32'h1600_0000, 32'hFF00_0000);
      wr(SRSS_REG_CTRL, 32'h21);
      pin(SRSS_PIN_RES, 1'b1);
      pin(SRSS_PIN_RES, 1'b0);
      rd(SRSS_REG_STATUS, 32'h0, 32'hFF00_0000);
      // cable bit drops inside reset so the restored wiring setting never mismatches
      @(posedge clk);
      p[SRSS_PIN_ENC4] <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(SRSS_REG_CTRL, 32'h1, 32'h3F);
      pin(SRSS_PIN_ST1, 1'b0); // both starts off while servo-on stays on
      // position mode: equal starts no longer steer stopping
      wr(SRSS_REG_CTRL, 32'h0);
      rd(SRSS_REG_STATUS, 32'h02, 32'h1F);
      pin(SRSS_PIN_SON, 1'b0);
      rd(SRSS_REG_STATUS, 32'h04, 32'h1F);
      `CHK(drive.base_drive_on, 1'b0)
      repeat (4) @(posedge clk);
      results();
   end
endmodule : srss_supervisor_tb_top
`default_nettype wire
